// ### logic/fssc_dev.sv
// Flash status and security control: the device end.
// Assumes the controller decodes command sequences and sends one cmd_wr
// per completed final write cycle.
`timescale 1ns/10ps
`default_nettype none
`include "fssc_cfg.svh"
module fssc_dev
  import fssc_pkg::*;
#(
  parameter int WINDOW_CYC = `FSSC_WINDOW_CYC,
  parameter int LIMIT_CYC  = `FSSC_LIMIT_CYC,
  parameter int OP_CYC     = `FSSC_OP_CYC
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Link
  fssc_if.dev       lnk,
  // Array side
  output logic      sec_access,
  output logic      sec_bit,
  output logic      busy
);
  fssc_state_t  st_ff;
  fssc_state_t  nxt_st;
  logic         sel_ff;
  logic [1:0]   rsv_ff;
  logic [7:0]   last_ff;
  logic [23:0]  lat_ff;
  logic         erase_ff;
  logic         tlim_ff;
  logic         sec_ff;
  logic [7:0]   rdata_ff;
  logic [31:0]  reg_rdata_ff;
  logic         t_load;
  logic [15:0]  t_count;
  logic         t_exp;
  logic         cmd_ok;
  logic         rdy;

  fssc_timer #(.W(16)) fssc_timer_inst (
    .core_clk (core_clk),
    .resetn   (resetn),
    .load     (t_load),
    .count    (t_count),
    .expired  (t_exp)
  );

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  // Window still accepts block erase; everything else only in read mode
  assign cmd_ok = lnk.cmd_wr && (st_ff == FSSC_READ ||
                  (st_ff == FSSC_WINDOW && lnk.cmd == `FSSC_CMD_BERASE));

  always_comb begin
    nxt_st  = st_ff;
    t_load  = 1'b0;
    t_count = 16'(OP_CYC);
    if (cmd_ok) begin
      case (lnk.cmd)
        `FSSC_CMD_PROG, `FSSC_CMD_CERASE, `FSSC_CMD_SEC: begin
          nxt_st = (lnk.cmd == `FSSC_CMD_PROG) ? FSSC_PROG : FSSC_ERASE;
          t_load = 1'b1;
        end
        `FSSC_CMD_BAD_PROG: begin
          nxt_st  = FSSC_PROG;
          t_load  = 1'b1;
          t_count = 16'(LIMIT_CYC);
        end
        `FSSC_CMD_BERASE: begin
          nxt_st  = FSSC_WINDOW;
          t_load  = 1'b1;
          t_count = 16'(WINDOW_CYC);
        end
        default: nxt_st = st_ff;
      endcase
    end else if (lnk.cmd_wr && st_ff == FSSC_FAIL && lnk.cmd == `FSSC_CMD_RESET) begin
      nxt_st = FSSC_READ;
    end else if (lnk.cmd_wr && st_ff == FSSC_WINDOW) begin
      nxt_st = FSSC_READ;
    end else if (t_exp) begin
      case (st_ff)
        FSSC_WINDOW: begin
          nxt_st = FSSC_ERASE;
          t_load = 1'b1;
        end
        FSSC_PROG, FSSC_ERASE: nxt_st = tlim_ff ? FSSC_FAIL : FSSC_READ;
        default:               nxt_st = st_ff;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn)
      st_ff <= FSSC_READ;
    else
      st_ff <= nxt_st;
  end

  // Failure marker: set when an illegal program is accepted, cleared on the next return to read mode
  always_ff @(posedge core_clk) begin
    if (!resetn)
      tlim_ff <= 1'b0;
    else if (cmd_ok && lnk.cmd == `FSSC_CMD_BAD_PROG)
      tlim_ff <= 1'b1;
    else if (nxt_st == FSSC_READ)
      tlim_ff <= 1'b0;
  end

  // Latch address and data at final write; frozen afterwards
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lat_ff   <= 24'h000000;
      last_ff  <= 8'h00;
      erase_ff <= 1'b0;
    end else if (cmd_ok && lnk.cmd != `FSSC_CMD_RESET) begin
      lat_ff   <= lnk.addr;
      last_ff  <= lnk.wdata;
      erase_ff <= (lnk.cmd == `FSSC_CMD_BERASE || lnk.cmd == `FSSC_CMD_CERASE ||
                   lnk.cmd == `FSSC_CMD_SEC);
    end
  end

  // Security bit tracks any completed erase-state operation (erase or security) while select is set
  always_ff @(posedge core_clk) begin
    if (!resetn)
      sec_ff <= 1'b0;
    else if (st_ff == FSSC_ERASE && t_exp && !tlim_ff && sel_ff)
      sec_ff <= (last_ff == 8'h00) ? 1'b0 : 1'b1;
  end

  // --------------------------------------------------------------
  // Status reads
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
    end else if (lnk.rd) begin
      rdata_ff <= last_ff;
      case (st_ff)
        FSSC_PROG: rdata_ff[`FSSC_DQ_POLL] <= ~last_ff[`FSSC_DQ_POLL];
        FSSC_ERASE, FSSC_WINDOW: rdata_ff[`FSSC_DQ_POLL] <= 1'b0;
        FSSC_FAIL: rdata_ff[`FSSC_DQ_POLL] <= erase_ff ? 1'b0 : ~last_ff[`FSSC_DQ_POLL];
        default:   rdata_ff[`FSSC_DQ_POLL] <= erase_ff ? 1'b1 : last_ff[`FSSC_DQ_POLL];
      endcase
      rdata_ff[`FSSC_DQ_TLIM] <= (st_ff == FSSC_FAIL);
      rdata_ff[`FSSC_DQ_WIN]  <= (st_ff == FSSC_ERASE) ||
                                 (st_ff == FSSC_FAIL && erase_ff);
    end
  end
  assign lnk.rdata = rdata_ff;

  // --------------------------------------------------------------
  // Control/status register
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sel_ff <= 1'b0;
      rsv_ff <= 2'h0;
    end else if (lnk.reg_wr && lnk.reg_addr == `FSSC_REG_CS) begin
      sel_ff <= lnk.reg_wdata[`FSSC_BIT_SEL];
      rsv_ff <= {lnk.reg_wdata[3], lnk.reg_wdata[1]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn)
      reg_rdata_ff <= 32'h00000000;
    else if (lnk.reg_rd && lnk.reg_addr == `FSSC_REG_CS)
      reg_rdata_ff <= {24'h000000, 4'h0, rsv_ff[1], rdy, rsv_ff[0], sel_ff};
    else
      reg_rdata_ff <= 32'h00000000;
  end
  assign lnk.reg_rdata = reg_rdata_ff;

  // --------------------------------------------------------------
  // Ready and array side
  // --------------------------------------------------------------
  // Window still counts as ready: only its expiry clears the flag
  assign rdy         = (st_ff == FSSC_READ) || (st_ff == FSSC_WINDOW);
  assign busy        = !rdy;
  assign lnk.rdy_pin = lnk.prog_mode ? rdy : 1'b0;
  assign sec_access  = sel_ff;
  assign sec_bit     = sec_ff;
endmodule
`default_nettype wire

// ### inc/fssc_cfg.svh
// Constants for the flash status and security control block.
// Assumes a 125 MHz core clock.
`ifndef FSSC_CFG_SVH
`define FSSC_CFG_SVH

`define FSSC_CLK_MHZ         125
`define FSSC_WINDOW_US       50
`define FSSC_WINDOW_CYC      (`FSSC_WINDOW_US * `FSSC_CLK_MHZ)
`define FSSC_LIMIT_CYC       1000
`define FSSC_OP_CYC          200
// Register offset of the control/status word
`define FSSC_REG_CS          32'hFFFFE520
`define FSSC_CS_RESET        8'h04
`define FSSC_BIT_SEL         0
`define FSSC_BIT_RDY         2
`define FSSC_DQ_POLL         7
`define FSSC_DQ_TLIM         5
`define FSSC_DQ_WIN          3
// Controller registers
`define FSSC_HREG_CMD        4'h0
`define FSSC_HREG_ADDR       4'h1
`define FSSC_HREG_DATA       4'h2
`define FSSC_HREG_STAT       4'h3
`define FSSC_HREG_POLL       4'h4
`define FSSC_HREG_MODE       4'h5
// Command codes on the link
`define FSSC_CMD_PROG        3'h1
`define FSSC_CMD_BERASE      3'h2
`define FSSC_CMD_CERASE      3'h3
`define FSSC_CMD_SEC         3'h4
`define FSSC_CMD_RESET       3'h5
`define FSSC_CMD_BAD_PROG    3'h6

`endif

// ### inc/fssc_pkg.sv
// Types of the flash status and security control block.
// Assumes nothing beyond the constants header.
package fssc_pkg;
  typedef enum logic [2:0] {
    FSSC_READ,
    FSSC_WINDOW,
    FSSC_PROG,
    FSSC_ERASE,
    FSSC_FAIL
  } fssc_state_t;
endpackage

// ### inc/fssc_if.sv
// Link between the flash status block and its controller.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface fssc_if;
  logic        cmd_wr;
  logic [2:0]  cmd;
  logic [23:0] addr;
  logic [7:0]  wdata;
  logic        rd;
  logic [7:0]  rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        prog_mode;
  logic        rdy_pin;
  modport dev (input cmd_wr, cmd, addr, wdata, rd, reg_wr, reg_rd, reg_addr, reg_wdata,
               prog_mode, output rdata, reg_rdata, rdy_pin);
  modport ctl (output cmd_wr, cmd, addr, wdata, rd, reg_wr, reg_rd, reg_addr, reg_wdata,
               prog_mode, input rdata, reg_rdata, rdy_pin);
endinterface
`default_nettype wire

// ### logic/fssc_timer.sv
// Down counter for the acceptance window and the operation times.
// Assumes one synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module fssc_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  // Status
  output logic              expired
);
  logic [W-1:0] cnt_ff;
  logic         run_ff;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end else if (load) begin
      cnt_ff <= count;
      run_ff <= 1'b1;
    end else if (run_ff) begin
      cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
      if (cnt_ff == {{(W-1){1'b0}}, 1'b1})
        run_ff <= 1'b0;
    end
  end

  assign expired = run_ff && (cnt_ff == {{(W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// ### logic/fssc_ctl.sv
// Flash status and security control: the controller end.
// Assumes software drives the plain register port of this module.
`timescale 1ns/10ps
`default_nettype none
`include "fssc_cfg.svh"
module fssc_ctl
  import fssc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Software port
  input  wire logic [3:0]  sw_addr,
  input  wire logic [31:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic [31:0]      sw_rdata,
  // Link
  fssc_if.ctl              lnk
);
  logic [23:0] addr_ff;
  logic [7:0]  data_ff;
  logic [7:0]  poll_ff;
  logic        cmd_wr_ff;
  logic [2:0]  cmd_ff;
  logic        rd_ff;
  logic        rd_d_ff;
  logic [31:0] sw_rdata_ff;
  logic        prog_mode_ff;

  // --------------------------------------------------------------
  // Orders to the device
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      addr_ff   <= 24'h000000;
      data_ff   <= 8'h00;
      cmd_wr_ff <= 1'b0;
      cmd_ff    <= 3'h0;
      rd_ff     <= 1'b0;
    end else begin
      cmd_wr_ff <= sw_wr && sw_addr == `FSSC_HREG_CMD;
      rd_ff     <= sw_wr && sw_addr == `FSSC_HREG_POLL;
      if (sw_wr && sw_addr == `FSSC_HREG_CMD)
        cmd_ff <= sw_wdata[2:0];
      if (sw_wr && sw_addr == `FSSC_HREG_ADDR)
        addr_ff <= {sw_wdata[23:2], 2'b00};
      if (sw_wr && sw_addr == `FSSC_HREG_DATA)
        data_ff <= sw_wdata[7:0];
    end
  end

  // Programmer mode lets the link's ready pin follow the device
  always_ff @(posedge core_clk) begin
    if (!resetn)
      prog_mode_ff <= 1'b0;
    else if (sw_wr && sw_addr == `FSSC_HREG_MODE)
      prog_mode_ff <= sw_wdata[0];
  end

  // Poll result lands one cycle after the device read
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_d_ff <= 1'b0;
      poll_ff <= 8'h00;
    end else begin
      rd_d_ff <= rd_ff;
      if (rd_d_ff)
        poll_ff <= lnk.rdata;
    end
  end

  assign lnk.cmd_wr    = cmd_wr_ff;
  assign lnk.cmd       = cmd_ff;
  assign lnk.addr      = addr_ff;
  assign lnk.wdata     = data_ff;
  assign lnk.rd        = rd_ff;
  assign lnk.prog_mode = prog_mode_ff;
  // Control/status word: writes pass bit 0 only, reads pass all 32 bits
  assign lnk.reg_wr    = sw_wr && sw_addr == `FSSC_HREG_STAT;
  assign lnk.reg_rd    = sw_rd && sw_addr == `FSSC_HREG_STAT;
  assign lnk.reg_addr  = `FSSC_REG_CS;
  assign lnk.reg_wdata = {28'h0000000, 1'b0, 2'b00, sw_wdata[0]} & 32'h00000001;

  // --------------------------------------------------------------
  // Software reads
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn)
      sw_rdata_ff <= 32'h00000000;
    else if (sw_rd && sw_addr == `FSSC_HREG_ADDR)
      sw_rdata_ff <= {8'h00, addr_ff};
    else if (sw_rd && sw_addr == `FSSC_HREG_DATA)
      sw_rdata_ff <= {24'h000000, data_ff};
    else if (sw_rd && sw_addr == `FSSC_HREG_POLL)
      sw_rdata_ff <= {24'h000000, poll_ff};
    else if (sw_rd && sw_addr == `FSSC_HREG_MODE)
      sw_rdata_ff <= {30'h00000000, lnk.rdy_pin, prog_mode_ff};
    else
      sw_rdata_ff <= 32'h00000000;
  end
  // Status reads come from the device one cycle later already
  assign sw_rdata = sw_rdata_ff | lnk.reg_rdata;
endmodule
`default_nettype wire

// ### bench/fssc_asserts.sv
// Checker on the link that joins the device end and the controller end.
// Assumes one clock, a sync active-low reset and the bench's timer values.
`timescale 1ns/10ps
`default_nettype none
`include "fssc_cfg.svh"
module fssc_asserts #(
  parameter int WINDOW_CYC = `FSSC_WINDOW_CYC,
  parameter int LIMIT_CYC  = `FSSC_LIMIT_CYC,
  parameter int OP_CYC     = `FSSC_OP_CYC
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // Link
  input wire logic        cmd_wr,
  input wire logic [2:0]  cmd,
  input wire logic [7:0]  wdata,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_rdata,
  input wire logic        prog_mode,
  input wire logic        rdy_pin
);
  logic [15:0] since_ff;
  logic [2:0]  last_cmd_ff;
  logic        last_d7_ff;
  // ----
  // Helper state
  // ----
  always_ff @(posedge core_clk) begin
    if (!resetn) since_ff <= 16'hFFFF;
    else if (cmd_wr) since_ff <= 16'h0000;
    else if (since_ff != 16'hFFFF) since_ff <= since_ff + 16'h0001;
  end
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      last_cmd_ff <= 3'h0;
      last_d7_ff  <= 1'b0;
    end else if (cmd_wr) begin
      last_cmd_ff <= cmd;
      last_d7_ff  <= wdata[7];
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_status;
    rd ##1 1'b1;
  endsequence
  sequence s_cs_read;
    reg_rd && reg_addr == `FSSC_REG_CS ##1 1'b1;
  endsequence
  sequence s_cs_read_prog;
    reg_rd && reg_addr == `FSSC_REG_CS && prog_mode ##1 1'b1;
  endsequence
  a_pin_idle_low: assert property (!prog_mode |-> !rdy_pin)
    else $error("ready pin high outside programmer mode");
  a_pin_tracks_rdy: assert property (s_cs_read_prog |-> reg_rdata[2] == $past(rdy_pin))
    else $error("ready pin differs from ready bit in programmer mode");
  a_cs_upper_zero: assert property (s_cs_read |-> reg_rdata[31:8] == 24'h000000)
    else $error("status word upper bits not zero");
  a_cs_must_zero: assert property (s_cs_read |-> !reg_rdata[3] && !reg_rdata[1])
    else $error("status word bits 3 or 1 set");
  a_cmd_one_pulse: assert property (cmd_wr |=> !cmd_wr)
    else $error("command strobe longer than one cycle");
  a_limit_after_time: assert property (s_status |-> !rdata[5] || since_ff >= LIMIT_CYC)
    else $error("time flag set before the limit");
  a_window_flag_wait: assert property (s_status |-> !(last_cmd_ff == `FSSC_CMD_BERASE
    && rdata[3] && since_ff < WINDOW_CYC))
    else $error("window flag set inside the window");
  a_erase_poll_low: assert property (s_status |-> !(last_cmd_ff == `FSSC_CMD_BERASE
    && since_ff < WINDOW_CYC) || !rdata[7])
    else $error("poll flag high during erase");
  a_prog_poll_inv: assert property (s_status |-> !(last_cmd_ff == `FSSC_CMD_PROG
    && since_ff < OP_CYC - 4) || rdata[7] == !last_d7_ff)
    else $error("poll flag not inverted during program");
endmodule
`default_nettype wire

// ### bench/flash_status_and_security_control_tb.sv
// Self-checking bench: both ends joined by the link, software port driven.
// Assumes shortened timer parameters so each operation lasts tens of cycles.
`timescale 1ns/10ps
`default_nettype none
`include "fssc_cfg.svh"
module flash_status_and_security_control_tb;
  localparam int WIN = 20;
  localparam int LIM = 30;
  localparam int OPC = 40;
  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic [3:0]  sw_addr  = 4'h0;
  logic [31:0] sw_wdata = 32'h00000000;
  logic        sw_wr    = 1'b0;
  logic        sw_rd    = 1'b0;
  logic [31:0] sw_rdata;
  logic        sec_access;
  logic        sec_bit;
  logic        busy;
  int          fail_count = 0;
  int          n_tests    = 0;
  // ----
  // Design, link and checker
  // ----
  fssc_if lnk_if ();
  always #4 core_clk = ~core_clk;
  fssc_dev #(.WINDOW_CYC(WIN), .LIMIT_CYC(LIM), .OP_CYC(OPC)) fssc_dev_inst (
    .core_clk(core_clk), .resetn(resetn), .lnk(lnk_if), .sec_access(sec_access),
    .sec_bit(sec_bit), .busy(busy));
  fssc_ctl fssc_ctl_inst (.core_clk(core_clk), .resetn(resetn), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .lnk(lnk_if));
  fssc_asserts #(.WINDOW_CYC(WIN), .LIMIT_CYC(LIM), .OP_CYC(OPC)) fssc_asserts_inst (
    .core_clk(core_clk), .resetn(resetn), .cmd_wr(lnk_if.cmd_wr), .cmd(lnk_if.cmd),
    .wdata(lnk_if.wdata), .rd(lnk_if.rd), .rdata(lnk_if.rdata), .reg_rd(lnk_if.reg_rd),
    .reg_addr(lnk_if.reg_addr), .reg_rdata(lnk_if.reg_rdata),
    .prog_mode(lnk_if.prog_mode), .rdy_pin(lnk_if.rdy_pin));
  // ----
  // Shared tasks
  // ----
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    sw_wr    <= 1'b1;
    sw_addr  <= a;
    sw_wdata <= v;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    sw_rd   <= 1'b1;
    sw_addr <= a;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
  endtask
  task automatic issue(input logic [2:0] c, input logic [7:0] v);
    sw_write(`FSSC_HREG_ADDR, 32'h00000100);
    sw_write(`FSSC_HREG_DATA, {24'h000000, v});
    sw_write(`FSSC_HREG_CMD, {29'h00000000, c});
  endtask
  task automatic poll(output logic [7:0] s);
    logic [31:0] r;
    sw_write(`FSSC_HREG_POLL, 32'h00000000);
    repeat (3) @(posedge core_clk);
    sw_read(`FSSC_HREG_POLL, r);
    s = r[7:0];
  endtask
  task automatic stat(input string name, input logic [2:0] exp);
    logic [31:0] r;
    sw_read(`FSSC_HREG_STAT, r);
    check(name, {29'h00000000, r[2:0]}, {29'h00000000, exp});
  endtask
  task automatic wait_ready();
    logic [31:0] r;
    int          i;
    r = 32'h00000000;
    for (i = 0; i < 300 && r[2] !== 1'b1; i++) begin
      sw_read(`FSSC_HREG_STAT, r);
    end
    check("ready", {31'h00000000, r[2]}, 32'h00000001);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    logic [31:0] r;
    sw_read(`FSSC_HREG_STAT, r);
    check("cs reset", r, {24'h000000, `FSSC_CS_RESET});
    check("select low", {31'h00000000, sec_access}, 32'h00000000);
    check("busy reset", {31'h00000000, busy}, 32'h00000000);
    sw_read(4'hF, r);
    check("unmapped", r, 32'h00000000);
    $display("test reset done");
  endtask
  task automatic t_prog();
    logic [7:0] s;
    issue(`FSSC_CMD_PROG, 8'h00);
    poll(s);
    check("prog poll", {24'h000000, s & 8'hA0}, 32'h00000080);
    stat("prog rdy", 3'h0);
    check("busy out", {31'h00000000, busy}, 32'h00000001);
    sw_write(`FSSC_HREG_CMD, {29'h00000000, `FSSC_CMD_CERASE});
    wait_ready();
    poll(s);
    check("prog done", {24'h000000, s & 8'hA0}, 32'h00000000);
    repeat (OPC) @(posedge core_clk);
    stat("busy cmd ignored", 3'h4);
    $display("test program done");
  endtask
  task automatic t_berase();
    logic [7:0] s;
    issue(`FSSC_CMD_BERASE, 8'h00);
    poll(s);
    check("window poll", {24'h000000, s & 8'hA8}, 32'h00000000);
    sw_write(`FSSC_HREG_CMD, {29'h00000000, `FSSC_CMD_BERASE});
    stat("window rdy", 3'h4);
    repeat (12) @(posedge core_clk);
    poll(s);
    check("window restart", {24'h000000, s & 8'h08}, 32'h00000000);
    repeat (WIN) @(posedge core_clk);
    stat("erase rdy", 3'h0);
    poll(s);
    check("erase flag", {24'h000000, s & 8'hA8}, 32'h00000008);
    wait_ready();
    poll(s);
    check("erase done", {24'h000000, s & 8'hA0}, 32'h00000080);
    $display("test block erase done");
  endtask
  task automatic t_fail();
    logic [7:0] s;
    issue(`FSSC_CMD_BAD_PROG, 8'h00);
    repeat (LIM + 20) @(posedge core_clk);
    poll(s);
    check("limit poll", {24'h000000, s & 8'hA0}, 32'h000000A0);
    stat("fail rdy", 3'h0);
    sw_write(`FSSC_HREG_CMD, {29'h00000000, `FSSC_CMD_RESET});
    repeat (4) @(posedge core_clk);
    stat("recovered rdy", 3'h4);
    poll(s);
    check("recovered poll", {24'h000000, s & 8'h20}, 32'h00000000);
    $display("test failure done");
  endtask
  task automatic t_sec();
    logic [31:0] r;
    sw_write(`FSSC_HREG_STAT, 32'hFFFFFFFF);
    sw_read(`FSSC_HREG_STAT, r);
    check("cs write", r, 32'h00000005);
    check("select out", {31'h00000000, sec_access}, 32'h00000001);
    issue(`FSSC_CMD_SEC, 8'h01);
    wait_ready();
    check("security on", {31'h00000000, sec_bit}, 32'h00000001);
    sw_write(`FSSC_HREG_STAT, 32'h00000000);
    stat("cs clear", 3'h4);
    $display("test security done");
  endtask
  task automatic t_pin();
    logic [31:0] r;
    logic [7:0]  s;
    sw_write(`FSSC_HREG_MODE, 32'h00000001);
    sw_read(`FSSC_HREG_MODE, r);
    check("pin ready", r, 32'h00000003);
    issue(`FSSC_CMD_PROG, 8'h80);
    stat("pin busy cs", 3'h0);
    sw_read(`FSSC_HREG_MODE, r);
    check("pin busy", r, 32'h00000001);
    wait_ready();
    poll(s);
    check("prog true data", {24'h000000, s & 8'hA0}, 32'h00000080);
    sw_write(`FSSC_HREG_MODE, 32'h00000000);
    sw_read(`FSSC_HREG_MODE, r);
    check("pin off", r, 32'h00000000);
    $display("test ready pin done");
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_prog();
    t_berase();
    t_fail();
    t_sec();
    t_pin();
    results();
  end
  initial begin
    #200000;
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
